// ---- src/isabl_master.sv ----
// Purpose: master end, turns user requests into steered bus transfers
// Assumes: a two-entry buffer absorbs requests while a transfer runs
// Notes: i_alt_owner releases all address and strobe drive
// Notes: a read keeps the bus until its response is taken, so reads never overlap
`timescale 1ns/1ps
module isabl_master
  import isabl_pkg::*;
#(
  parameter int P_DEPTH = 2
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  isabl_if.master bus,
  input wire logic i_alt_owner,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic [ISABL_FULL_AW-1:0] i_req_addr,
  input wire logic i_req_write,
  input wire logic i_req_io,
  input wire logic [1:0] i_req_bytes,
  input wire logic [15:0] i_req_wdata,
  output logic o_rsp_valid,
  input wire logic i_rsp_ready,
  output logic [15:0] o_rsp_data,
  output logic o_busy
);
  localparam int RW = ISABL_FULL_AW + 2 + 2 + 16;
  typedef enum logic [1:0] {
    ISABL_IDLE = 2'b00,
    ISABL_ADDR = 2'b01,
    ISABL_DATA = 2'b10,
    ISABL_WAIT = 2'b11
  } isabl_state_e;
  isabl_state_e state_reg;
  logic [RW-1:0] fifo [P_DEPTH];
  logic [$clog2(P_DEPTH)-1:0] wp_reg;
  logic [$clog2(P_DEPTH)-1:0] rp_reg;
  logic [$clog2(P_DEPTH):0] cnt_reg;
  logic [$clog2(P_DEPTH):0] cnt_next;
  logic [RW-1:0] cur_reg;
  logic [ISABL_UA_W-1:0] ua_reg;
  logic [ISABL_SA_W-1:0] sa_reg;
  logic hbe_n_reg;
  logic drv_reg;
  logic ale_reg;
  logic wr_reg;
  logic doe_reg;
  logic rsp_reg;
  logic [15:0] d_reg;
  logic push, pop;
  logic [1:0] ln;
  isabl_xfer_e kind;
  logic [RW-1:0] head;
  logic [ISABL_FULL_AW-1:0] head_addr;
  logic head_write;
  logic [1:0] head_bytes;

  assign push = i_req_valid && o_req_ready;
  assign pop = (state_reg == ISABL_IDLE) && (cnt_reg != '0) && !i_alt_owner;
  assign cnt_next = cnt_reg + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
  // buffer entry: {address, write, io, byte count, write data}
  assign head = fifo[rp_reg];
  assign head_addr = head[RW-1 -: ISABL_FULL_AW];
  assign head_write = head[19];
  assign head_bytes = head[17:16];
  // every word request asserts the high strobe; at an odd address only the odd byte then moves
  function automatic logic hbe_for(input logic [1:0] bytes);
    hbe_for = (bytes != 2'd2);
  endfunction
  assign ln = isabl_lanes(hbe_n_reg, sa_reg[0]);
  assign kind = isabl_xfer_e'({hbe_n_reg, sa_reg[0]});

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      o_req_ready <= 1'b1;
    end else begin
      if (push) wp_reg <= wp_reg + 1'b1;
      if (pop) rp_reg <= rp_reg + 1'b1;
      cnt_reg <= cnt_next;
      o_req_ready <= cnt_next < P_DEPTH;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (push) fifo[wp_reg] <= {i_req_addr, i_req_write, i_req_io, i_req_bytes, i_req_wdata};
  end
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= ISABL_IDLE;
      cur_reg <= '0;
      ua_reg <= ISABL_UA_RST;
      sa_reg <= ISABL_SA_RST;
      hbe_n_reg <= 1'b1;
      ale_reg <= 1'b0;
      wr_reg <= 1'b0;
      doe_reg <= 1'b0;
      d_reg <= 16'h0000;
    end else begin
      case (state_reg)
        ISABL_IDLE: begin
          if (pop) begin
            cur_reg <= head;
            ua_reg <= head_addr[ISABL_UA_LSB +: ISABL_UA_W];
            sa_reg <= head_addr[ISABL_SA_W-1:0];
            hbe_n_reg <= hbe_for(head_bytes);
            wr_reg <= head_write;
            ale_reg <= 1'b1;
            state_reg <= ISABL_ADDR;
          end
        end
        ISABL_ADDR: begin
          ale_reg <= 1'b0;
          doe_reg <= wr_reg;
          case (kind)
            ISABL_XFER_WORD: d_reg <= cur_reg[15:0];
            ISABL_XFER_ODD_HI: d_reg <= {cur_reg[7:0], 8'hFF};
            ISABL_XFER_EVEN_LO: d_reg <= {8'hFF, cur_reg[7:0]};
            ISABL_XFER_ODD_LO: d_reg <= {8'hFF, cur_reg[7:0]};
            default: d_reg <= {8'hFF, cur_reg[7:0]};
          endcase
          state_reg <= ISABL_DATA;
        end
        ISABL_DATA: begin
          doe_reg <= 1'b0;
          state_reg <= ISABL_WAIT;
        end
        ISABL_WAIT: begin
          if (!rsp_reg) state_reg <= ISABL_IDLE;
        end
        default: state_reg <= ISABL_IDLE;
      endcase
    end
  end

  // drive released while an alternate master owns the bus
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      drv_reg <= 1'b0;
    end else begin
      drv_reg <= !i_alt_owner;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rsp_reg <= 1'b0;
      o_rsp_data <= 16'h0000;
    end else if (state_reg == ISABL_DATA && !wr_reg) begin
      // wait one more cycle: the adapter answers after the strobe falls
      rsp_reg <= 1'b1;
    end else if (state_reg == ISABL_WAIT && rsp_reg && !o_rsp_valid) begin
      case (ln)
        2'b11: o_rsp_data <= bus.data_bus;
        2'b10: o_rsp_data <= {8'h00, bus.data_bus[15:8]};
        default: o_rsp_data <= {8'h00, bus.data_bus[7:0]};
      endcase
    end else if (o_rsp_valid && i_rsp_ready) begin
      rsp_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rsp_valid <= 1'b0;
    end else if (o_rsp_valid && i_rsp_ready) begin
      o_rsp_valid <= 1'b0;
    end else if (state_reg == ISABL_WAIT && rsp_reg) begin
      o_rsp_valid <= 1'b1;
    end
  end

  // busy includes the pop edge so a caller sees no gap between buffer and bus
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (state_reg != ISABL_IDLE) || pop;
    end
  end

  assign bus.m_ua_o = ua_reg;
  assign bus.m_ua_oe = drv_reg;
  assign bus.m_sa_o = sa_reg;
  assign bus.m_sa_oe = drv_reg;
  assign bus.m_hbe_n_o = hbe_n_reg;
  assign bus.m_hbe_oe = drv_reg;
  assign bus.m_ale = ale_reg;
  assign bus.m_write = wr_reg;
  assign bus.m_d_o = d_reg;
  assign bus.m_d_oe = doe_reg && drv_reg;
endmodule

// ---- src/isabl_pkg.sv ----
// Purpose: shared constants and types for the expansion bus byte-lane blocks
// Assumes: one clock domain, address lanes as three-signal pins
// Notes: upper address selects a 128KB region of a 16MB space
package isabl_pkg;
  localparam int ISABL_UA_W = 7;
  localparam int ISABL_UA_LSB = 17;
  localparam int ISABL_SA_W = 20;
  localparam int ISABL_LANE_W = 8;
  localparam int ISABL_FULL_AW = 24;
  localparam logic [ISABL_UA_W-1:0] ISABL_UA_RST = 7'h00;
  localparam logic [ISABL_SA_W-1:0] ISABL_SA_RST = 20'h00000;
  localparam logic [ISABL_LANE_W-1:0] ISABL_LANE_RST = 8'h00;

  typedef enum logic [1:0] {
    ISABL_XFER_WORD = 2'b00,
    ISABL_XFER_ODD_HI = 2'b01,
    ISABL_XFER_EVEN_LO = 2'b10,
    ISABL_XFER_ODD_LO = 2'b11
  } isabl_xfer_e;

  // {upper enable, lower enable} from strobe and address bit zero
  function automatic logic [1:0] isabl_lanes(input logic hbe_n, input logic a0);
    case ({hbe_n, a0})
      2'b00: isabl_lanes = 2'b11;
      2'b01: isabl_lanes = 2'b10;
      2'b10: isabl_lanes = 2'b01;
      default: isabl_lanes = 2'b01;
    endcase
  endfunction
endpackage

// ---- src/isabl_if.sv ----
// Purpose: expansion bus wires between a master end and an adapter end
// Assumes: master drives address and strobe, data driven by either side
// Notes: resolves three-state pins from the output enables
`timescale 1ns/1ps
interface isabl_if;
  import isabl_pkg::*;
  logic [ISABL_UA_W-1:0] m_ua_o;
  logic m_ua_oe;
  logic [ISABL_SA_W-1:0] m_sa_o;
  logic m_sa_oe;
  logic m_hbe_n_o;
  logic m_hbe_oe;
  logic m_ale;
  logic m_write;
  logic [15:0] m_d_o;
  logic m_d_oe;
  logic [15:0] a_d_o;
  logic a_d_oe;
  logic a_wide_sel_n;
  logic [ISABL_UA_W-1:0] latched_upper_address;
  logic [ISABL_SA_W-1:0] system_address;
  logic high_byte_enable_n;
  logic [15:0] data_bus;
  assign latched_upper_address = m_ua_oe ? m_ua_o : '1;
  assign system_address = m_sa_oe ? m_sa_o : '1;
  assign high_byte_enable_n = m_hbe_oe ? m_hbe_n_o : 1'b1;
  assign data_bus = m_d_oe ? m_d_o : (a_d_oe ? a_d_o : 16'hFFFF);
  modport master (output m_ua_o, m_ua_oe, m_sa_o, m_sa_oe, m_hbe_n_o, m_hbe_oe, m_ale, m_write,
    m_d_o, m_d_oe, input data_bus, a_wide_sel_n);
  modport adapter (input latched_upper_address, system_address, high_byte_enable_n, m_ale,
    m_write, data_bus, output a_d_o, a_d_oe, a_wide_sel_n);
endinterface

// ---- src/isabl_adapter.sv ----
// Purpose: adapter end, a small 16-bit memory answering on both lanes
// Assumes: transfers are one-cycle commands framed by the address strobe
// Notes: wide select decoded from the upper address only
`timescale 1ns/1ps
module isabl_adapter
  import isabl_pkg::*;
#(
  parameter logic [ISABL_UA_W-1:0] P_REGION = 7'h01,
  parameter int P_DEPTH = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  isabl_if.adapter bus,
  output logic o_hit
);
  localparam int AW = $clog2(P_DEPTH);
  logic [ISABL_LANE_W-1:0] mem_lo [P_DEPTH];
  logic [ISABL_LANE_W-1:0] mem_hi [P_DEPTH];
  logic ale_reg;
  logic [ISABL_UA_W-1:0] ua_reg;
  logic [ISABL_SA_W-1:0] sa_reg;
  logic hbe_n_reg;
  logic wsel_n_reg;
  logic [15:0] rd_reg;
  logic rd_oe_reg;
  logic [1:0] ln;
  logic [AW-1:0] idx;
  logic hit;
  assign ln = isabl_lanes(hbe_n_reg, sa_reg[0]);
  assign idx = sa_reg[AW:1];
  assign hit = (ua_reg == P_REGION);
  assign bus.a_d_o = rd_reg;
  assign bus.a_d_oe = rd_oe_reg;
  assign bus.a_wide_sel_n = wsel_n_reg;
  // capture address on every clock while the latch strobe is high
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ale_reg <= 1'b0;
      ua_reg <= ISABL_UA_RST;
      sa_reg <= ISABL_SA_RST;
      hbe_n_reg <= 1'b1;
    end else begin
      ale_reg <= bus.m_ale;
      if (bus.m_ale) begin
        ua_reg <= bus.latched_upper_address;
        sa_reg <= bus.system_address;
        hbe_n_reg <= bus.high_byte_enable_n;
      end
    end
  end
  // wide select from the upper address alone, never from strobes
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) wsel_n_reg <= 1'b1;
    else wsel_n_reg <= !(bus.latched_upper_address == P_REGION);
  end
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) o_hit <= 1'b0;
    else o_hit <= hit;
  end
  wire cmd = ale_reg && !bus.m_ale && hit;
  always_ff @(posedge i_clk_sys) begin
    if (cmd && bus.m_write) begin
      if (ln == 2'b11) begin
        mem_lo[idx] <= bus.data_bus[7:0];
        mem_hi[idx] <= bus.data_bus[15:8];
      end else if (ln == 2'b10) begin
        mem_hi[idx] <= bus.data_bus[15:8];
      end else if (sa_reg[0]) begin
        mem_hi[idx] <= bus.data_bus[7:0];
      end else begin
        mem_lo[idx] <= bus.data_bus[7:0];
      end
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_reg <= 16'h0000;
      rd_oe_reg <= 1'b0;
    end else begin
      rd_oe_reg <= cmd && !bus.m_write;
      if (cmd && !bus.m_write) begin
        rd_reg[15:8] <= mem_hi[idx];
        rd_reg[7:0] <= (ln == 2'b01 && sa_reg[0]) ? mem_hi[idx] : mem_lo[idx];
      end
    end
  end
endmodule

// ---- verif/isabl_asserts.sv ----
// Purpose: wire checks between master and adapter ends
// Assumes: one clock, async active-low reset
// Notes: sees only the interface, so request intent is not known
`timescale 1ns/1ps
module isabl_asserts
  import isabl_pkg::*;
#(
  parameter logic [ISABL_UA_W-1:0] P_REGION = 7'h01
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic m_ua_oe,
  input wire logic m_sa_oe,
  input wire logic m_hbe_oe,
  input wire logic m_ale,
  input wire logic m_write,
  input wire logic m_d_oe,
  input wire logic a_d_oe,
  input wire logic [ISABL_UA_W-1:0] latched_upper_address,
  input wire logic [ISABL_SA_W-1:0] system_address,
  input wire logic high_byte_enable_n
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  ale_spacing_a: assert property (m_ale |=> !m_ale ##1 !m_ale)
    else $error("address strobe too close");
  drive_together_a: assert property (m_ua_oe == m_sa_oe && m_ua_oe == m_hbe_oe)
    else $error("address drives differ");
  ale_driven_a: assert property (m_ale |-> m_ua_oe && m_hbe_oe)
    else $error("strobe without drive");
  write_drive_a: assert property (m_ale && m_write |=> m_d_oe)
    else $error("write data late");
  drive_single_a: assert property (m_d_oe |=> !m_d_oe)
    else $error("data drive too long");
  no_contention_a: assert property (!(m_d_oe && a_d_oe))
    else $error("both ends drive data");
  addr_hold_a: assert property (m_d_oe |-> $stable(system_address) && $stable(high_byte_enable_n))
    else $error("address moved under data");
  read_answer_a: assert property (m_ale && !m_write && latched_upper_address == P_REGION |-> ##[1:3] a_d_oe)
    else $error("adapter did not answer");
  cover property (m_ale && m_write && !high_byte_enable_n && !system_address[0]);
  cover property (m_ale && high_byte_enable_n && system_address[0]);
  cover property (a_d_oe);
endmodule

// ---- verif/isa_style_bus_byte_lanes_tb_top.sv ----
// Purpose: both ends joined, lanes and buffer checked
// Assumes: inputs driven at falling edge
// Notes: adapter region is 7'h01
`timescale 1ns/1ps
module isa_style_bus_byte_lanes_tb_top;
  import isabl_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_reset_n = 1'b0;
  logic alt = 1'b0;
  logic vld = 1'b0;
  logic wr = 1'b0;
  logic rrdy = 1'b0;
  logic [23:0] addr = 24'h000000;
  logic [1:0] nb = 2'h0;
  logic [15:0] wd = 16'h0000;
  logic rdy, rv, busy, hit;
  logic [15:0] rd;
  int err_count = 0;
  int comparisons = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  isabl_if bus_if ();
  isabl_master isabl_master_inst (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .bus(bus_if.master),
    .i_alt_owner(alt), .i_req_valid(vld), .o_req_ready(rdy), .i_req_addr(addr), .i_req_write(wr),
    .i_req_io(1'b0), .i_req_bytes(nb), .i_req_wdata(wd), .o_rsp_valid(rv), .i_rsp_ready(rrdy),
    .o_rsp_data(rd), .o_busy(busy));
  isabl_adapter isabl_adapter_inst (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .bus(bus_if.adapter), .o_hit(hit));
  isabl_asserts isabl_asserts_inst (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .m_ua_oe(bus_if.m_ua_oe),
    .m_sa_oe(bus_if.m_sa_oe), .m_hbe_oe(bus_if.m_hbe_oe), .m_ale(bus_if.m_ale), .m_write(bus_if.m_write),
    .m_d_oe(bus_if.m_d_oe), .a_d_oe(bus_if.a_d_oe), .latched_upper_address(bus_if.latched_upper_address),
    .system_address(bus_if.system_address), .high_byte_enable_n(bus_if.high_byte_enable_n));
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chkb(input string w, input logic e, input logic g);
    chk(w, {15'h0000, e}, {15'h0000, g});
  endtask
  // leaves valid high so back-to-back pushes need no extra edge
  task automatic push(input logic [23:0] a, input logic w, input logic [1:0] n, input logic [15:0] d);
    int k;
    addr = a;
    wr = w;
    nb = n;
    wd = d;
    vld = 1'b1;
    k = 0;
    while (rdy !== 1'b1 && k < 50) begin
      @(negedge i_clk_sys);
      k++;
    end
    if (rdy !== 1'b1) chkb("request ready", 1'b1, rdy);
    @(negedge i_clk_sys);
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int k;
    k = 0;
    while (s !== v && k < 50) begin
      @(negedge i_clk_sys);
      k++;
    end
    if (s !== v) chkb("handshake wait", v, s);
  endtask
  task automatic wrw(input logic [23:0] a, input logic [1:0] n, input logic [15:0] d, input logic hb,
    input logic [15:0] m);
    push(a, 1'b1, n, d);
    vld = 1'b0;
    wait_for(bus_if.m_ale, 1'b1);
    chk("upper address", {9'h000, a[23:17]}, {9'h000, bus_if.latched_upper_address});
    chkb("address bit zero", a[0], bus_if.system_address[0]);
    chkb("high byte enable", hb, bus_if.high_byte_enable_n);
    @(negedge i_clk_sys);
    chk("data lanes", d & m, bus_if.data_bus & m);
    chkb("wide select", a[23:17] != 7'h01, bus_if.a_wide_sel_n);
    wait_for(busy, 1'b0);
  endtask
  task automatic rdw(input logic [23:0] a, input logic [1:0] n, input logic [15:0] m, input logic [15:0] e);
    push(a, 1'b0, n, 16'h0000);
    vld = 1'b0;
    wait_for(rv, 1'b1);
    repeat (2) @(negedge i_clk_sys);
    chkb("response held", 1'b1, rv);
    chk("read data", e & m, rd & m);
    chkb("adapter hit", a[23:17] == 7'h01, hit);
    rrdy = 1'b1;
    @(negedge i_clk_sys);
    rrdy = 1'b0;
    chkb("response taken", 1'b0, rv);
    wait_for(busy, 1'b0);
  endtask
  initial begin
    repeat (20) @(negedge i_clk_sys);
    i_reset_n = 1'b1;
    @(negedge i_clk_sys);
    wrw(24'h020004, 2'h2, 16'hA55A, 1'b0, 16'hFFFF);
    wrw(24'h020008, 2'h1, 16'h0011, 1'b1, 16'h00FF);
    wrw(24'h020009, 2'h1, 16'h0022, 1'b1, 16'h00FF);
    wrw(24'h02000B, 2'h2, 16'h4444, 1'b0, 16'hFF00);
    rdw(24'h02000B, 2'h1, 16'h00FF, 16'h0044);
    rdw(24'h020004, 2'h2, 16'hFFFF, 16'hA55A);
    rdw(24'h020008, 2'h2, 16'hFFFF, 16'h2211);
    rdw(24'h020005, 2'h1, 16'h00FF, 16'h00A5);
    $display("test lanes done");
    alt = 1'b1;
    @(negedge i_clk_sys);
    chkb("address released", 1'b0, bus_if.m_ua_oe);
    chkb("strobe released", 1'b1, bus_if.high_byte_enable_n);
    push(24'h020010, 1'b1, 2'h2, 16'h1234);
    push(24'h020012, 1'b1, 2'h2, 16'h5678);
    chkb("buffer full", 1'b0, rdy);
    vld = 1'b0;
    alt = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    wait_for(busy, 1'b0);
    rdw(24'h020010, 2'h2, 16'hFFFF, 16'h1234);
    rdw(24'h020012, 2'h2, 16'hFFFF, 16'h5678);
    $display("test alternate owner done");
    wrw(24'h040004, 2'h2, 16'hDEAD, 1'b0, 16'hFFFF);
    rdw(24'h020004, 2'h2, 16'hFFFF, 16'hA55A);
    rdw(24'h040004, 2'h2, 16'hFFFF, 16'hFFFF);
    $display("test region done");
    end_of_test();
  end
  initial begin
    #(5 * 5000);
    err_count++;
    end_of_test();
  end
endmodule
